// ==== supervisor_status_lock_regs.sv ====
// Purpose: Bank-zero status and protection registers of the supervisor.
// Assumes: One clock; the serial front end hands over decoded byte requests.
// Notes:   Read data is registered; answers appear one cycle after a request.
//
// Functional notes
// (R1) Report watchdog phase as three-bit code.
// (R2) Set expiry on short close or open timeout.
// (R3) Reading flag register clears expiry flag.
// (R4) Set fault on extra or wrong answer.
// (R5) Reading flag register clears answer fault.
// (R6) Live two-bit answer tally, reset three.
// (R7) Live token, reset twelve, zeroed on enable.
// (R8) Three read-only channel voltage telemetry bytes.
// (R9) Bit zero of page register selects bank.
// (R10) Writes blocked only if both locks set.
// (R11) Fixed group lock bit positions, both registers.
// (R12) Channel locks with group lock; reset locked.
// (R13) Address register: OTP part, strap part.
// (R14) Fail-safe uses OTP default address forty-eight.
// (R15) Read-only writes ignored; watchdog status reserved bits zero.
// (R16) Single clock domain; all state resets.
`timescale 1ns/1ps
`include "ssl_defines.svh"
module supervisor_status_lock_regs
    import ssl_pkg::*;
(
    // Clock and reset.
    input  wire logic          clk_sys,
    input  wire logic          rst,
    // Register port from the serial front end.
    input  wire ssl_req_type   req,
    // Watchdog engine events.
    input  wire ssl_wdev_type  wdEv,
    // Converter telemetry for channels 2 to 4.
    input  wire logic [7:0]    lvl2,
    input  wire logic [7:0]    lvl3,
    input  wire logic [7:0]    lvl4,
    // Address sources and bus failure.
    input  wire logic [3:0]    otpAddressBits,
    input  wire logic [2:0]    strapAddressBits,
    input  wire logic          busFailed,
    // Register answer.
    output logic [7:0]         rdata_ff,
    output logic               rvalid_ff,
    // Bank, lock and address outputs.
    output logic               bankOne_ff,
    output ssl_lock_type       locks_ff,
    output logic [6:0]         targetAddr_ff
);
    typedef struct packed {
        logic [7:0]   rdata;
        logic         rvalid;
        logic         bankOne;
        ssl_lock_type locks;
        logic [6:0]   targetAddr;
        logic [3:0]   otp;
        logic [2:0]   strap;
        logic         addrLoaded;
    } ssl_top_type;

    ssl_top_type  stateFf;
    ssl_top_type  nxtState;
    logic [7:0]   flagByte;
    logic [7:0]   qaByte;
    logic [7:0]   pageByte;
    logic [7:0]   lockAByte;
    logic [7:0]   lockBByte;
    logic [7:0]   chLockByte;
    ssl_lock_type lockNow;
    logic         bank0;
    logic         wrPage;
    logic         wrLockA;
    logic         wrLockB;
    logic         wrChLock;
    logic         flagRdClr;
    logic [7:0]   rdMux;

    // Bank-zero decode; the page register stays reachable from either bank.
    assign bank0    = !stateFf.bankOne;
    // (R15) only writable offsets
    assign wrPage   = req.wr && req.addr == `SSL_OFF_PAGE;
    assign wrLockA  = req.wr && bank0 && req.addr == `SSL_OFF_LOCKA;
    assign wrLockB  = req.wr && bank0 && req.addr == `SSL_OFF_LOCKB;
    assign wrChLock = req.wr && bank0 && req.addr == `SSL_OFF_CHLOCK;
    // (R3) read clears flags
    assign flagRdClr = req.rd && bank0 && req.addr == `SSL_OFF_WDSTAT;

    ssl_wd_status u_wd (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .wdEv      (wdEv),
        .flagRdClr (flagRdClr),
        .flagByte  (flagByte),
        .qaByte    (qaByte)
    );

    ssl_lock_regs u_lock (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .wrPage     (wrPage),
        .wrLockA    (wrLockA),
        .wrLockB    (wrLockB),
        .wrChLock   (wrChLock),
        .wdata      (req.wdata),
        .pageByte   (pageByte),
        .lockAByte  (lockAByte),
        .lockBByte  (lockBByte),
        .chLockByte (chLockByte),
        .locks      (lockNow)
    );

    // Read multiplexer; flag byte is captured before the clear lands.
    always_comb begin
        rdMux = 8'h00;
        if (req.addr == `SSL_OFF_PAGE) begin
            rdMux = pageByte;
        end else if (!bank0) begin
            rdMux = 8'h00;
        end else if (req.addr == `SSL_OFF_WDSTAT) begin
            rdMux = flagByte;
        end else if (req.addr == `SSL_OFF_WDQA) begin
            rdMux = qaByte;
        // (R8) telemetry read path
        end else if (req.addr == `SSL_OFF_LVL2) begin
            rdMux = lvl2;
        end else if (req.addr == `SSL_OFF_LVL3) begin
            rdMux = lvl3;
        end else if (req.addr == `SSL_OFF_LVL4) begin
            rdMux = lvl4;
        end else if (req.addr == `SSL_OFF_LOCKA) begin
            rdMux = lockAByte;
        end else if (req.addr == `SSL_OFF_LOCKB) begin
            rdMux = lockBByte;
        end else if (req.addr == `SSL_OFF_CHLOCK) begin
            rdMux = chLockByte;
        // (R13) composed address read
        end else if (req.addr == `SSL_OFF_ADDR) begin
            rdMux = {1'b0, stateFf.otp, stateFf.strap};
        end
    end

    // Next state for answer, bank, locks and address.
    always_comb begin
        nxtState        = stateFf;
        nxtState.rvalid = req.rd;
        if (req.rd) nxtState.rdata = rdMux;
        // (R9) bank select bit
        nxtState.bankOne = wrPage ? req.wdata[0] : stateFf.bankOne;
        nxtState.locks   = lockNow;
        // Straps are caught once after reset, not under it.
        if (!stateFf.addrLoaded) begin
            nxtState.otp        = otpAddressBits;
            nxtState.strap      = strapAddressBits;
            nxtState.addrLoaded = 1'b1;
        end
        // (R14) fail-safe address
        if (busFailed) begin
            nxtState.targetAddr = `SSL_FAILSAFE_ADDR;
        end else begin
            nxtState.targetAddr = {stateFf.otp, stateFf.strap};
        end
    end

    // (R16) synchronous reset values
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            stateFf <= '{8'h00, 1'b0, 1'b0, '0, `SSL_FAILSAFE_ADDR,
                         `SSL_RST_OTP_ADDR, 3'h0, 1'b0};
        end else begin
            stateFf <= nxtState;
        end
    end

    assign rdata_ff      = stateFf.rdata;
    assign rvalid_ff     = stateFf.rvalid;
    assign bankOne_ff    = stateFf.bankOne;
    assign locks_ff      = stateFf.locks;
    assign targetAddr_ff = stateFf.targetAddr;

    // Assertions.
    property p_read_clears;
        @(posedge clk_sys) disable iff (rst)
        (flagRdClr && !wdEv.openExpired && !wdEv.closeExpired) |=> !flagByte[2];
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("expiry not cleared"); // (R3)

    property p_fault_clears;
        @(posedge clk_sys) disable iff (rst)
        (flagRdClr && !wdEv.answerWrong && !wdEv.answerGood) |=> !flagByte[0];
    endproperty
    a_fault_clears: assert property (p_fault_clears) else $error("fault not cleared"); // (R5)

    property p_open_exp;
        @(posedge clk_sys) disable iff (rst) wdEv.openExpired |=> flagByte[2];
    endproperty
    a_open_exp: assert property (p_open_exp) else $error("open expiry missed"); // (R2)

    property p_wrong_ans;
        @(posedge clk_sys) disable iff (rst) wdEv.answerWrong |=> flagByte[0];
    endproperty
    a_wrong_ans: assert property (p_wrong_ans) else $error("wrong answer missed"); // (R4)

    property p_phase;
        @(posedge clk_sys) disable iff (rst) ##1 flagByte[5:3] == $past(wdEv.phase);
    endproperty
    a_phase: assert property (p_phase) else $error("phase mismatch"); // (R1)

    property p_token_zero;
        @(posedge clk_sys) disable iff (rst)
        $rose(wdEv.wdEnable) |=> qaByte[3:0] == 4'h0;
    endproperty
    a_token_zero: assert property (p_token_zero) else $error("token not zeroed"); // (R7)

    property p_dual_lock;
        @(posedge clk_sys) disable iff (rst)
        1'b1 |=> locks_ff.setup == $past(lockAByte[3] && lockBByte[3]);
    endproperty
    a_dual_lock: assert property (p_dual_lock) else $error("dual lock wrong"); // (R10)

    property p_reserved_zero;
        @(posedge clk_sys) disable iff (rst)
        rvalid_ff |-> !($past(req.addr) == `SSL_OFF_WDQA && $past(bank0)) || rdata_ff[7:6] == 2'b00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set"); // (R15)

    property p_failsafe;
        @(posedge clk_sys) disable iff (rst) busFailed |=> targetAddr_ff == 7'h30;
    endproperty
    a_failsafe: assert property (p_failsafe) else $error("fail-safe address wrong"); // (R14)

    c_flag_read: cover property (@(posedge clk_sys) flagRdClr && flagByte[2]);
    c_bank_one:  cover property (@(posedge clk_sys) bankOne_ff);
    c_locked:    cover property (@(posedge clk_sys) locks_ff.working);
endmodule : supervisor_status_lock_regs

// ==== ssl_defines.svh ====
// Purpose: Offsets, field positions, reset values for the supervisor status and lock bank.
// Assumes: Eight-bit register addresses and data on an internal register port.
// Notes:   Included by every design module that needs the map, not by the package.
`ifndef SSL_DEFINES_SVH
`define SSL_DEFINES_SVH
`define SSL_OFF_WDSTAT      8'h37
`define SSL_OFF_WDQA        8'h38
`define SSL_OFF_LVL2        8'h41
`define SSL_OFF_LVL3        8'h42
`define SSL_OFF_LVL4        8'h43
`define SSL_OFF_PAGE        8'hF0
`define SSL_OFF_LOCKA       8'hF1
`define SSL_OFF_LOCKB       8'hF2
`define SSL_OFF_CHLOCK      8'hF3
`define SSL_OFF_ADDR        8'hF9
`define SSL_RST_QA_TALLY    2'h3
`define SSL_RST_QA_TOKEN    4'hC
`define SSL_RST_CHLOCK      8'h1F
`define SSL_RST_OTP_ADDR    4'h6
`define SSL_BIT_EXPIRED     2
`define SSL_BIT_FAULT       0
`define SSL_BIT_WORKING     5
`define SSL_BIT_SETUP       3
`define SSL_BIT_IRQEN       2
`define SSL_BIT_CHANNEL     1
`define SSL_BIT_ORDERING    0
`define SSL_LOCK_MASK       8'h3F
`define SSL_CHLOCK_MASK     8'h0F
`define SSL_FAILSAFE_ADDR   7'h30
`endif

// ==== ssl_pkg.sv ====
// Purpose: Types shared by the supervisor status and lock bank.
// Assumes: Constants live in ssl_defines.svh.
// Notes:   Phase codes are binary as reported to the host.
package ssl_pkg;
    typedef enum logic [2:0] {
        SSL_PH_IDLE    = 3'h0,
        SSL_PH_OPEN    = 3'h1,
        SSL_PH_CLOSE   = 3'h2,
        SSL_PH_STARTUP = 3'h3,
        SSL_PH_SUSPEND = 3'h4
    } ssl_phase_type;

    // Register port request from the bus front end.
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ssl_req_type;

    // Watchdog events reported by the timing engine.
    typedef struct packed {
        logic          closeExpired;
        logic          openExpired;
        logic          answerGood;
        logic          answerWrong;
        logic          wdEnable;
        logic [3:0]    nextToken;
        logic          tokenLoad;
        ssl_phase_type phase;
    } ssl_wdev_type;

    // Effective write locks handed to bank-one logic.
    typedef struct packed {
        logic       working;
        logic       setup;
        logic       irqEn;
        logic       channel;
        logic       ordering;
        logic [2:0] chanLock;
    } ssl_lock_type;
endpackage : ssl_pkg

// ==== ssl_wd_status.sv ====
// Purpose: Watchdog phase, sticky flags, answer tally and question token.
// Assumes: Events arrive on clk_sys from the watchdog engine.
// Notes:   A set arriving with a read-clear wins, so no event is lost.
`timescale 1ns/1ps
`include "ssl_defines.svh"
module ssl_wd_status
    import ssl_pkg::*;
(
    // Clock and reset.
    input  wire logic          clk_sys,
    input  wire logic          rst,
    // Watchdog events.
    input  wire ssl_wdev_type  wdEv,
    // Read-clear strobe for the flag register.
    input  wire logic          flagRdClr,
    // Status out.
    output logic [7:0]         flagByte,
    output logic [7:0]         qaByte
);
    typedef struct packed {
        ssl_phase_type phase;
        logic          expired;
        logic          fault;
        logic [1:0]    tally;
        logic [3:0]    token;
        logic          enPrev;
    } ssl_wds_type;

    ssl_wds_type stateFf;
    ssl_wds_type nxtState;
    logic        closeWin;
    logic        setExp;
    logic        setFault;

    // Event decode; an extra answer is a fourth in close phase.
    always_comb begin
        closeWin = (stateFf.phase == SSL_PH_CLOSE);
        // (R2) expiry set causes
        setExp   = (wdEv.closeExpired && stateFf.tally != 2'd3) || wdEv.openExpired;
        // (R4) answer fault causes
        setFault = wdEv.answerWrong ||
                   (closeWin && wdEv.answerGood && stateFf.tally == 2'd3);
    end

    // Next state of all watchdog status.
    always_comb begin
        nxtState       = stateFf;
        // (R1) phase tracking live
        nxtState.phase = wdEv.phase;
        nxtState.enPrev = wdEv.wdEnable;
        // (R3) expiry read clear
        if (setExp) begin
            nxtState.expired = 1'b1;
        end else if (flagRdClr) begin
            nxtState.expired = 1'b0;
        end
        // (R5) fault read clear
        if (setFault) begin
            nxtState.fault = 1'b1;
        end else if (flagRdClr) begin
            nxtState.fault = 1'b0;
        end
        // (R6) answer tally update
        if (wdEv.answerGood && stateFf.tally != 2'd3) begin
            nxtState.tally = 2'(stateFf.tally + 2'd1);
        end else if (wdEv.tokenLoad) begin
            nxtState.tally = 2'd0;
        end
        // (R7) token forced zero
        if (wdEv.wdEnable && !stateFf.enPrev) begin
            nxtState.token = 4'h0;
        end else if (wdEv.tokenLoad) begin
            nxtState.token = wdEv.nextToken;
        end
    end

    // State register with reset values.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            stateFf <= '{SSL_PH_IDLE, 1'b0, 1'b0, `SSL_RST_QA_TALLY, `SSL_RST_QA_TOKEN, 1'b0};
        end else begin
            stateFf <= nxtState;
        end
    end

    // Reserved bits read as zero.
    assign flagByte = {2'b00, stateFf.phase, stateFf.expired, 1'b0, stateFf.fault};
    assign qaByte   = {2'b00, stateFf.tally, stateFf.token};
endmodule : ssl_wd_status

// ==== ssl_lock_regs.sv ====
// Purpose: Page choice, dual write locks and channel locks.
// Assumes: Writes are qualified by the top-level decoder.
// Notes:   A lock acts only when both lock registers agree.
`timescale 1ns/1ps
`include "ssl_defines.svh"
module ssl_lock_regs
    import ssl_pkg::*;
(
    // Clock and reset.
    input  wire logic         clk_sys,
    input  wire logic         rst,
    // Write strobes and data.
    input  wire logic         wrPage,
    input  wire logic         wrLockA,
    input  wire logic         wrLockB,
    input  wire logic         wrChLock,
    input  wire logic [7:0]   wdata,
    // Stored values and effective locks.
    output logic [7:0]        pageByte,
    output logic [7:0]        lockAByte,
    output logic [7:0]        lockBByte,
    output logic [7:0]        chLockByte,
    output ssl_lock_type      locks
);
    typedef struct packed {
        logic [7:0] page;
        logic [7:0] lockA;
        logic [7:0] lockB;
        logic [7:0] chLock;
    } ssl_lks_type;

    ssl_lks_type stateFf;
    ssl_lks_type nxtState;
    logic [7:0]  both;

    // Register writes; reserved bits are kept as written.
    always_comb begin
        nxtState = stateFf;
        // (R9) page bit write
        if (wrPage) nxtState.page = wdata;
        if (wrLockA) nxtState.lockA = wdata;
        if (wrLockB) nxtState.lockB = wdata;
        if (wrChLock) nxtState.chLock = wdata;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            stateFf <= '{8'h00, 8'h00, 8'h00, `SSL_RST_CHLOCK};
        end else begin
            stateFf <= nxtState;
        end
    end

    // (R10) both lock registers
    assign both = stateFf.lockA & stateFf.lockB & `SSL_LOCK_MASK;
    // (R11) group bit placement
    assign locks.working  = both[`SSL_BIT_WORKING];
    assign locks.setup    = both[`SSL_BIT_SETUP];
    assign locks.irqEn    = both[`SSL_BIT_IRQEN];
    assign locks.channel  = both[`SSL_BIT_CHANNEL];
    assign locks.ordering = both[`SSL_BIT_ORDERING];
    // (R12) channel lock combine
    assign locks.chanLock = stateFf.chLock[3:1] & {3{both[`SSL_BIT_CHANNEL]}};

    assign pageByte   = stateFf.page;
    assign lockAByte  = stateFf.lockA;
    assign lockBByte  = stateFf.lockB;
    assign chLockByte = stateFf.chLock;
endmodule : ssl_lock_regs

// ==== ssl_host_model.sv ====
// Purpose: Behavioural host that issues byte requests on the register port.
// Assumes: Requests change at the falling edge and are taken on the rising one.
// Notes:   Released address and data lines show the inverse of the last value.
`timescale 1ns/1ps
module ssl_host_model
    import ssl_pkg::*;
(
    // Clock.
    input  wire logic       clk_sys,
    // Register port.
    output ssl_req_type     req,
    input  wire logic [7:0] rdata_ff,
    input  wire logic       rvalid_ff
);
    // The port is idle until the bench asks for a transfer.
    initial begin
        req = '0;
    end

    // One write byte, held across exactly one rising edge.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        req = '{1'b0, 1'b1, a, d};
        @(negedge clk_sys);
        req = '{1'b0, 1'b0, ~a, ~d};
    endtask : wr

    // One read byte; the answer is taken while the valid pulse stands.
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(negedge clk_sys);
        req = '{1'b1, 1'b0, a, 8'h00};
        @(negedge clk_sys);
        req = '{1'b0, 1'b0, ~a, 8'hFF};
        ok = rvalid_ff;
        d = rdata_ff;
    endtask : rd
endmodule : ssl_host_model

// ==== supervisor_status_lock_regs_tb.sv ====
// Purpose: Self-checking bench for the status and lock bank.
// Assumes: A model of integers predicts every read byte and lock output.
// Notes:   Events are kept clear of reads so the read-clear order is known.
`timescale 1ns/1ps
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin nFail++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module supervisor_status_lock_regs_tb
    import ssl_pkg::*;
;
    logic         clk_sys = 1'b0;
    logic         rst = 1'b1;
    ssl_req_type  req;
    ssl_wdev_type wdEv;
    logic [7:0]   lvl2, lvl3, lvl4, rdata_ff, got, a, b, c;
    logic [3:0]   otpAddressBits;
    logic [2:0]   strapAddressBits;
    logic         busFailed, rvalid_ff, bankOne_ff, ok;
    ssl_lock_type locks_ff;
    logic [6:0]   targetAddr_ff;
    int nFail, nTests, cycles, seed = 93460;
    int mPhase, mExp, mFlt, mTally, mToken, mPage, mLockA, mLockB, mCh;
    logic [7:0] addrs [11] = '{8'h37, 8'h38, 8'h41, 8'h42, 8'h43, 8'hF0,
                               8'hF1, 8'hF2, 8'hF3, 8'hF9, 8'h55};

    supervisor_status_lock_regs supervisor_status_lock_regs_inst (
        .clk_sys(clk_sys), .rst(rst), .req(req), .wdEv(wdEv), .lvl2(lvl2),
        .lvl3(lvl3), .lvl4(lvl4), .otpAddressBits(otpAddressBits),
        .strapAddressBits(strapAddressBits), .busFailed(busFailed),
        .rdata_ff(rdata_ff), .rvalid_ff(rvalid_ff), .bankOne_ff(bankOne_ff),
        .locks_ff(locks_ff), .targetAddr_ff(targetAddr_ff));
    ssl_host_model ssl_host_model_inst (
        .clk_sys(clk_sys), .req(req), .rdata_ff(rdata_ff), .rvalid_ff(rvalid_ff));

    // Clock of 5 ns.
    always #2.5 clk_sys = ~clk_sys;

    // Hang guard; the sequence needs well under a thousand cycles.
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            nFail++;
            endOfTest();
        end
    end

    // Byte the model predicts; in bank one only the page choice is visible.
    function automatic logic [7:0] expByte(input logic [7:0] x);
        if (mPage[0] && x != 8'hF0) return 8'h00;
        case (x)
            8'h37: return {2'b00, mPhase[2:0], mExp[0], 1'b0, mFlt[0]};
            8'h38: return {2'b00, mTally[1:0], mToken[3:0]};
            8'h41: return lvl2;
            8'h42: return lvl3;
            8'h43: return lvl4;
            8'hF0: return mPage[7:0];
            8'hF1: return mLockA[7:0];
            8'hF2: return mLockB[7:0];
            8'hF3: return mCh[7:0];
            8'hF9: return {1'b0, otpAddressBits, strapAddressBits};
            default: return 8'h00;
        endcase
    endfunction : expByte

    task automatic endOfTest();
        $display("Comparisons %0d, mismatches %0d", nTests, nFail);
        if (nFail == 0 && nTests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : endOfTest

    task automatic idle(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : idle

    // Read one byte, compare it, then apply the read-clear to the model.
    task automatic rdChk(input logic [7:0] x);
        logic [7:0] e;
        e = expByte(x);
        ssl_host_model_inst.rd(x, got, ok);
        `CHK(ok, 1'b1)
        `CHK(got, e)
        if (x == 8'h37 && !mPage[0]) begin
            mExp = 0;
            mFlt = 0;
        end
    endtask : rdChk

    task automatic rdAll();
        foreach (addrs[i]) rdChk(addrs[i]);
    endtask : rdAll

    // One-cycle event pulse: 0 close end, 1 open end, 2 good, 3 wrong, 4 load.
    task automatic pulse(input int k);
        @(negedge clk_sys);
        wdEv.closeExpired = (k == 0);
        wdEv.openExpired = (k == 1);
        wdEv.answerGood = (k == 2);
        wdEv.answerWrong = (k == 3);
        wdEv.tokenLoad = (k == 4);
        @(negedge clk_sys);
        {wdEv.closeExpired, wdEv.openExpired, wdEv.answerGood} = 3'b000;
        {wdEv.answerWrong, wdEv.tokenLoad} = 2'b00;
        idle(2);
    endtask : pulse

    task automatic setPhase(input int p);
        @(negedge clk_sys);
        wdEv.phase = ssl_phase_type'(p[2:0]);
        mPhase = p;
        idle(3);
    endtask : setPhase

    // Main sequence.
    initial begin
        wdEv = '0;
        lvl2 = 8'($random(seed));
        lvl3 = 8'($random(seed));
        lvl4 = 8'($random(seed));
        otpAddressBits = 4'($random(seed));
        strapAddressBits = 3'($random(seed));
        busFailed = 1'b0;
        {mPhase, mExp, mFlt, mTally, mToken} = {32'd0, 32'd0, 32'd0, 32'd3, 32'd12};
        {mPage, mLockA, mLockB, mCh} = {32'd0, 32'd0, 32'd0, 32'h1F};
        idle(7);
        rst = 1'b0;
        idle(2);
        rdAll();
        `CHK(targetAddr_ff, {otpAddressBits, strapAddressBits})
        busFailed = 1'b1;
        idle(3);
        `CHK(targetAddr_ff, 7'h30)
        busFailed = 1'b0;
        // Writes to read-only and unmapped places leave everything unchanged.
        foreach (addrs[i]) if (addrs[i] < 8'hF0 || addrs[i] == 8'hF9)
            ssl_host_model_inst.wr(addrs[i], 8'($random(seed)));
        rdAll();
        for (int p = 0; p < 5; p++) begin
            setPhase(p);
            rdChk(8'h37);
        end
        setPhase(2);
        // The tally already stands at three from reset: a close end is no expiry.
        pulse(0);
        rdChk(8'h37);
        pulse(4);
        {mTally, mToken} = {32'd0, 32'd0};
        pulse(0);
        mExp = 1;
        rdChk(8'h37);
        rdChk(8'h37);
        pulse(1);
        mExp = 1;
        rdChk(8'h37);
        rdChk(8'h37);
        wdEv.wdEnable = 1'b1;
        mToken = 0;
        idle(3);
        rdChk(8'h38);
        wdEv.nextToken = 4'($random(seed));
        mToken = wdEv.nextToken;
        pulse(4);
        mTally = 0;
        rdChk(8'h38);
        for (int n = 0; n < 3; n++) begin
            pulse(2);
            mTally++;
            rdChk(8'h38);
        end
        pulse(2);
        mFlt = 1;
        rdChk(8'h37);
        rdChk(8'h37);
        pulse(3);
        mFlt = 1;
        rdChk(8'h37);
        setPhase(1);
        pulse(3);
        mFlt = 1;
        rdChk(8'h37);
        for (int n = 0; n < 5; n++) begin
            @(negedge clk_sys);
            {lvl2, lvl3, lvl4} = 24'($random(seed));
            rdChk(8'h41);
            rdChk(8'h42);
            rdChk(8'h43);
        end
        for (int n = 0; n < 8; n++) begin
            a = (n == 0) ? 8'h3F : (8'($random(seed)) & 8'h3F);
            b = (n == 0) ? 8'h3F : (8'($random(seed)) & 8'h3F);
            c = (n == 0) ? 8'h0E : (8'($random(seed)) & 8'h0E);
            ssl_host_model_inst.wr(8'hF1, a);
            ssl_host_model_inst.wr(8'hF2, b);
            ssl_host_model_inst.wr(8'hF3, c);
            {mLockA, mLockB, mCh} = {24'd0, a, 24'd0, b, 24'd0, c};
            idle(3);
            rdChk(8'hF1);
            rdChk(8'hF2);
            rdChk(8'hF3);
            a = a & b;
            `CHK(locks_ff, {a[5], a[3], a[2], a[1], a[0], c[3:1] & {3{a[1]}}})
        end
        // The host selects bank one before touching it, and back again.
        ssl_host_model_inst.wr(8'hF0, 8'h01);
        mPage = 1;
        idle(2);
        `CHK(bankOne_ff, 1'b1)
        ssl_host_model_inst.wr(8'hF1, 8'h15);
        rdAll();
        ssl_host_model_inst.wr(8'hF0, 8'h00);
        mPage = 0;
        idle(2);
        `CHK(bankOne_ff, 1'b0)
        rdChk(8'hF1);
        endOfTest();
    end
endmodule : supervisor_status_lock_regs_tb
